// file: hw/bfi_pkg.sv
// Package: constants for the boot flash inquiry responder
package bfi_pkg;
  localparam logic [7:0] CMD_AREA_INQ = 8'h25;
  localparam logic [7:0] RSP_AREA_INQ = 8'h35;
  localparam logic [7:0] CMD_BLOCK_INQ = 8'h26;
  localparam logic [7:0] RSP_BLOCK_INQ = 8'h36;
  localparam logic [7:0] AREA_COUNT = 8'h01;
  localparam int ADDR_BYTES = 4;
  localparam int BLOCK_COUNT = 4;
  localparam logic [31:0] AREA_START = 32'h0000_0000;
  localparam logic [31:0] AREA_END = 32'h0000_ffff;
  localparam logic [31:0] BLOCK_SIZE = 32'h0000_4000;
  localparam logic [7:0] BUF_DEPTH = 8'h02;
  typedef enum logic [2:0] {
    BFI_IDLE,
    BFI_CODE,
    BFI_SIZE,
    BFI_COUNT,
    BFI_ADDR,
    BFI_SUM
  } bfi_state_e;
endpackage

// file: hw/bfi_stream_if.sv
// Interface: byte stream with valid and ready
`timescale 1ns/1ps
interface bfi_stream_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// file: hw/bfi_skid_buf.sv
// Two-entry byte buffer with registered outputs
`timescale 1ns/1ps
module bfi_skid_buf
  import bfi_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  bfi_stream_if.snk in_s,
  output logic [7:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  logic [7:0] mem_reg [2];
  logic [7:0] mem_next [2];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic push;
  logic pop;
  logic wr_idx;
  logic valid_reg;
  logic valid_next;

  always_comb
  begin
    pop = o_valid && i_ready;
    push = in_s.valid && (cnt_reg != BUF_DEPTH[1:0]);
    // Write slot shifts down on a pop
    wr_idx = cnt_reg[0] && !pop;
    mem_next = mem_reg;
    cnt_next = cnt_reg;
    if (pop)
    begin
      mem_next[0] = mem_reg[1];
    end
    if (push)
    begin
      mem_next[wr_idx] = in_s.data;
    end
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    valid_next = (cnt_next != 2'h0);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      mem_reg[0] <= 8'h00;
      mem_reg[1] <= 8'h00;
      cnt_reg <= 2'h0;
      valid_reg <= 1'b0;
    end
    else
    begin
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
      valid_reg <= valid_next;
    end
  end

  assign in_s.ready = (cnt_reg != BUF_DEPTH[1:0]);
  assign o_data = mem_reg[0];
  assign o_valid = valid_reg;
endmodule

// file: hw/bfi_responder.sv
// Top: answers flash area and erase block inquiries with framed bytes
// Behaviour
// - Command 25h asks area layout; answer opens with code 35h.
// - Size byte gives length of count plus all address fields.
// - Area count byte is 01h for one contiguous flash area.
// - Each area sends 4-byte start then 4-byte end address.
// - Every answer ends with one checksum byte after last address.
// - Command 26h asks erase blocks; answer opens with code 36h.
// - Block answer: size, block count, each block's start/end, checksum.
`timescale 1ns/1ps
module bfi_responder
  import bfi_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [7:0] i_cmd_data,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  output logic [7:0] o_rsp_data,
  output logic o_rsp_valid,
  input wire logic i_rsp_ready,
  output logic o_unknown_cmd
);
  bfi_stream_if st ();
  bfi_state_e state_reg;
  bfi_state_e state_next;
  logic blk_reg;
  logic blk_next;
  logic [7:0] sum_reg;
  logic [7:0] sum_next;
  logic [7:0] idx_reg;
  logic [7:0] idx_next;
  logic [2:0] byte_reg;
  logic [2:0] byte_next;
  logic ready_reg;
  logic ready_next;
  logic unk_reg;
  logic unk_next;
  logic [7:0] cur_byte;
  logic [7:0] npairs;
  logic [31:0] cur_addr;
  logic take;

  assign npairs = blk_reg ? 8'(BLOCK_COUNT) : AREA_COUNT;

  always_comb
  begin
    // Start address on even byte groups, end on odd
    if (blk_reg)
    begin
      cur_addr = AREA_START + BLOCK_SIZE * {24'h0, idx_reg >> 1}
        + (idx_reg[0] ? BLOCK_SIZE - 32'h1 : 32'h0);
    end
    else
    begin
      cur_addr = idx_reg[0] ? AREA_END : AREA_START;
    end
  end

  always_comb
  begin
    cur_byte = 8'h00;
    unique case (state_reg)
      BFI_IDLE: cur_byte = 8'h00;
      BFI_CODE: cur_byte = blk_reg ? RSP_BLOCK_INQ : RSP_AREA_INQ;
      BFI_SIZE: cur_byte = 8'(1 + 2 * ADDR_BYTES * int'(npairs));
      BFI_COUNT: cur_byte = npairs;
      BFI_ADDR: cur_byte = cur_addr[8'(31 - 8 * byte_reg) -: 8];
      BFI_SUM: cur_byte = 8'h00 - sum_reg;
    endcase
  end

  assign take = st.valid && st.ready;

  always_comb
  begin
    state_next = state_reg;
    blk_next = blk_reg;
    sum_next = sum_reg;
    idx_next = idx_reg;
    byte_next = byte_reg;
    unk_next = 1'b0;
    ready_next = 1'b0;
    if (state_reg == BFI_IDLE)
    begin
      ready_next = !(i_cmd_valid && ready_reg);
      if (i_cmd_valid && ready_reg)
      begin
        sum_next = 8'h00;
        idx_next = 8'h00;
        byte_next = 3'h0;
        if (i_cmd_data == CMD_AREA_INQ)
        begin
          blk_next = 1'b0;
          state_next = BFI_CODE;
        end
        else if (i_cmd_data == CMD_BLOCK_INQ)
        begin
          blk_next = 1'b1;
          state_next = BFI_CODE;
        end
        else
        begin
          unk_next = 1'b1;
          ready_next = 1'b1;
        end
      end
    end
    else if (take)
    begin
      sum_next = sum_reg + cur_byte;
      unique case (state_reg)
        BFI_CODE: state_next = BFI_SIZE;
        BFI_SIZE: state_next = BFI_COUNT;
        BFI_COUNT: state_next = BFI_ADDR;
        BFI_ADDR:
        begin
          byte_next = byte_reg + 3'h1;
          if (byte_reg == 3'(ADDR_BYTES - 1))
          begin
            byte_next = 3'h0;
            idx_next = idx_reg + 8'h1;
            if (idx_reg == 8'((int'(npairs) * 2) - 1))
            begin
              state_next = BFI_SUM;
            end
          end
        end
        BFI_SUM: state_next = BFI_IDLE;
        default: state_next = BFI_IDLE;
      endcase
      if (state_reg == BFI_SUM)
      begin
        ready_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_reg <= BFI_IDLE;
      blk_reg <= 1'b0;
      sum_reg <= 8'h00;
      idx_reg <= 8'h00;
      byte_reg <= 3'h0;
      ready_reg <= 1'b0;
      unk_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      blk_reg <= blk_next;
      sum_reg <= sum_next;
      idx_reg <= idx_next;
      byte_reg <= byte_next;
      ready_reg <= ready_next;
      unk_reg <= unk_next;
    end
  end

  assign st.data = cur_byte;
  assign st.valid = (state_reg != BFI_IDLE);
  assign o_cmd_ready = ready_reg;
  assign o_unknown_cmd = unk_reg;

  bfi_skid_buf u_buf (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .in_s(st),
    .o_data(o_rsp_data),
    .o_valid(o_rsp_valid),
    .i_ready(i_rsp_ready)
  );

  property p_area_code;
    @(posedge i_clk_sys) disable iff (i_reset)
    (state_reg == BFI_IDLE && ready_reg && i_cmd_valid && i_cmd_data == CMD_AREA_INQ)
      |=> (state_reg == BFI_CODE && cur_byte == RSP_AREA_INQ);
  endproperty
  a_area_code: assert property (p_area_code) else $error("area code wrong");

  property p_blk_code;
    @(posedge i_clk_sys) disable iff (i_reset)
    (state_reg == BFI_IDLE && ready_reg && i_cmd_valid && i_cmd_data == CMD_BLOCK_INQ)
      |=> (state_reg == BFI_CODE && cur_byte == RSP_BLOCK_INQ);
  endproperty
  a_blk_code: assert property (p_blk_code) else $error("block code wrong");

  property p_size;
    @(posedge i_clk_sys) disable iff (i_reset)
    (state_reg == BFI_SIZE) |-> cur_byte == 8'(1 + 8 * int'(npairs));
  endproperty
  a_size: assert property (p_size) else $error("size wrong");

  property p_count;
    @(posedge i_clk_sys) disable iff (i_reset)
    (state_reg == BFI_COUNT && !blk_reg) |-> cur_byte == 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("area count wrong");

  property p_addr_follow;
    @(posedge i_clk_sys) disable iff (i_reset)
    (state_reg == BFI_COUNT && take) |=> (state_reg == BFI_ADDR && byte_reg == 3'h0);
  endproperty
  a_addr_follow: assert property (p_addr_follow) else $error("no address");

  property p_sum_last;
    @(posedge i_clk_sys) disable iff (i_reset)
    (state_reg == BFI_SUM && take) |=> state_reg == BFI_IDLE;
  endproperty
  a_sum_last: assert property (p_sum_last) else $error("frame tail wrong");

  property p_blk_pairs;
    @(posedge i_clk_sys) disable iff (i_reset)
    (state_reg == BFI_ADDR) |-> idx_reg < 8'(2 * int'(npairs));
  endproperty
  a_blk_pairs: assert property (p_blk_pairs) else $error("too many pairs");

  property p_checksum;
    @(posedge i_clk_sys) disable iff (i_reset)
    (state_reg == BFI_SUM) |-> 8'(sum_reg + cur_byte) == 8'h00;
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum bad");
endmodule

// file: tb/bfi_host_model.sv
// Host model: collects response bytes, may stall
`timescale 1ns/1ps
module bfi_host_model
(
  input wire logic i_clk_sys,
  input wire logic [7:0] i_data,
  input wire logic i_valid,
  input wire logic i_slow,
  output logic o_ready
);
  logic [7:0] got [$];
  logic [1:0] tick = 2'h0;
  // Ready one cycle in three when slow
  assign o_ready = !i_slow || tick == 2'h0;
  // Stall pattern moves off the sampling edge
  always @(negedge i_clk_sys)
  begin
    tick <= (tick == 2'h2) ? 2'h0 : tick + 2'h1;
  end
  always @(posedge i_clk_sys)
  begin
    if (i_valid && o_ready)
      got.push_back(i_data);
  end
endmodule

// file: tb/bfi_responder_test.sv
// Testbench: inquiry responder against host model
`timescale 1ns/1ps
module bfi_responder_test;
  import bfi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cmd = 8'h00;
  logic cmd_v = 1'b0;
  logic slow = 1'b0;
  logic cmd_rdy, rsp_v, rsp_rdy, unk;
  logic [7:0] rsp_d;
  int err_count = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  bfi_responder uut (.i_clk_sys(clk), .i_reset(rst), .i_cmd_data(cmd),
    .i_cmd_valid(cmd_v), .o_cmd_ready(cmd_rdy), .o_rsp_data(rsp_d),
    .o_rsp_valid(rsp_v), .i_rsp_ready(rsp_rdy), .o_unknown_cmd(unk));
  bfi_host_model host (.i_clk_sys(clk), .i_data(rsp_d), .i_valid(rsp_v),
    .i_slow(slow), .o_ready(rsp_rdy));
  task automatic summarize();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // Hold command until ready seen, taken at next rising edge
  task automatic send(logic [7:0] c);
    int n;
    n = 0;
    @(negedge clk);
    cmd = c;
    cmd_v = 1'b1;
    while (cmd_rdy !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge clk);
    end
    if (n == 50)
    begin
      err_count++;
      summarize();
    end
    @(negedge clk);
    cmd_v = 1'b0;
  endtask
  task automatic frame(logic [7:0] c, logic [7:0] code, int cnt, logic [31:0] step);
    logic [7:0] exp [$];
    logic [31:0] a;
    logic [7:0] s;
    int n;
    exp = {code, 8'(1 + 8 * cnt), 8'(cnt)};
    for (int i = 0; i < cnt; i++)
    begin
      a = AREA_START + step * i;
      for (int k = 0; k < 8; k++)
        exp.push_back(8'((k < 4 ? a : a + step - 32'h1) >> (8 * (3 - k % 4))));
    end
    s = 8'h00;
    foreach (exp[i])
      s += exp[i];
    exp.push_back(8'h00 - s);
    host.got.delete();
    send(c);
    chk("cmd_ready busy", cmd_rdy, 8'h00);
    n = 0;
    while (host.got.size() < exp.size() && n < 500)
    begin
      n++;
      @(negedge clk);
    end
    if (n == 500)
    begin
      err_count++;
      summarize();
    end
    repeat (4) @(negedge clk);
    chk("frame length", 8'(host.got.size()), 8'(exp.size()));
    if (host.got.size() != exp.size())
      summarize();
    chk("code", host.got[0], exp[0]);
    chk("size", host.got[1], exp[1]);
    chk("count", host.got[2], exp[2]);
    for (int i = 3; i < exp.size() - 1; i++)
      chk("address", host.got[i], exp[i]);
    chk("checksum", host.got[exp.size() - 1], exp[exp.size() - 1]);
    s = 8'h00;
    foreach (host.got[i])
      s += host.got[i];
    chk("byte sum", s, 8'h00);
    chk("cmd_ready back", cmd_rdy, 8'h01);
  endtask
  task automatic unknown(logic [7:0] c);
    int hits;
    hits = 0;
    host.got.delete();
    send(c);
    repeat (6)
    begin
      if (unk === 1'b1)
        hits++;
      @(negedge clk);
    end
    chk("unknown pulse", 8'(hits), 8'h01);
    chk("no answer", 8'(host.got.size()), 8'h00);
    chk("ready kept", cmd_rdy, 8'h01);
  endtask
  // Reset in mid frame drops the answer
  task automatic reset_mid();
    send(CMD_BLOCK_INQ);
    repeat (3) @(negedge clk);
    rst = 1'b1;
    repeat (20) @(negedge clk);
    chk("valid in mid reset", rsp_v, 8'h00);
    chk("ready in mid reset", cmd_rdy, 8'h00);
    chk("unknown in mid reset", unk, 8'h00);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk("ready after reset", cmd_rdy, 8'h01);
    chk("valid after reset", rsp_v, 8'h00);
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    chk("valid in reset", rsp_v, 8'h00);
    rst = 1'b0;
    frame(CMD_AREA_INQ, RSP_AREA_INQ, 1, AREA_END - AREA_START + 32'h1);
    slow = 1'b1;
    frame(CMD_BLOCK_INQ, RSP_BLOCK_INQ, BLOCK_COUNT, BLOCK_SIZE);
    unknown(8'h27);
    frame(CMD_AREA_INQ, RSP_AREA_INQ, 1, AREA_END - AREA_START + 32'h1);
    slow = 1'b0;
    unknown(8'h00);
    reset_mid();
    frame(CMD_BLOCK_INQ, RSP_BLOCK_INQ, BLOCK_COUNT, BLOCK_SIZE);
    summarize();
  end
endmodule
